// *** motor_command_output_router.sv ***
// Per-motor command output router with backlash hysteresis tracking.
// Assumes the servo filter supplies commands and positions for the motor
// being served, and that the outside accepts one register write a clock.
//
// Functional notes
// - Backlash starts after reversal exceeds hysteresis
// - Hysteresis resets to 64 sixteenths
// - Inactive motors skip all computation and tracking
// - Deactivation freezes outputs, no forced safe state
// - Only motor 1 active after reset
// - Commutation off: one value, one address
// - Commutation on: two or three values
// - Address holds lowest register; bit19 selects X
// - Sign-magnitude: magnitude out, sign to flag bit14
// - Second generation: no sign-magnitude, digital pulses
// - First generation DAC pairs spaced eight apart
// - Second generation A DAC base plus 8(n-1)
// - Ring node register 0 base, step four
// - Pulse output uses C register, mode 2/3
// - Two values to address and next higher
// - Three values to address and next two
// - Bit16 with commutation and current loop 0 selects direct microstepping
`timescale 1ns/100ps

module motor_command_output_router
    import motor_router_pkg::*;
(
    input wire logic ref_clk_in, // 20 MHz clock
    input wire logic nrst_in, // Synchronous reset, active low
    input wire logic servo_tick_in, // Servo-cycle boundary pulse
    input wire logic second_gen_in, // 1 = second-generation variant
    input wire logic [22:0] backlash_hysteresis_in, // New hysteresis value
    input wire logic backlash_hysteresis_we_in, // Hysteresis write strobe
    input wire logic [7:0] motor_activation_in, // Requested activation
    input wire logic [7:0] commutation_enable_in, // Requested commutation
    input wire logic [7:0] current_loop_select_in, // Current loop of served motor
    input wire logic [19:0] command_output_address_in, // Address of served motor
    input wire logic [19:0] flag_register_address_in, // Flag address of served motor
    input wire logic [1:0] channel_output_mode_in, // Mode of served channel
    input wire logic [2:0] motor_sel_in, // Motor served this cycle
    input wire logic motor_go_in, // Start serving the selected motor
    input wire logic [31:0] commanded_pos_in, // Commanded position, 1/16 count
    input wire logic [23:0] cmd_a_in, // First command value
    input wire logic [23:0] cmd_b_in, // Second command value
    input wire logic [23:0] cmd_c_in, // Third command value
    output logic [22:0] backlash_hysteresis_out, // Active hysteresis
    output logic [7:0] active_motors_out, // Activation in force
    output logic [7:0] backlash_active_out, // Backlash applied per motor
    output logic [7:0] direction_out, // 1 = moving negative per motor
    output logic [2:0] route_mode_out, // Routing chosen for served motor
    output logic out_we_out, // Output register write strobe
    output logic out_space_x_out, // 1 = X space, 0 = Y space
    output logic [15:0] out_addr_out, // Output register address
    output logic [23:0] out_data_out, // Output register data
    output logic flag_we_out, // Flag direction bit write strobe
    output logic [15:0] flag_addr_out, // Flag register address
    output logic flag_dir_out, // Direction value, bit 14 of flag
    output logic busy_out // Write sequence in progress
);

    // ----------------------------------------------------------------
    // Settings: activation and commutation latched at servo boundaries, hysteresis on its write strobe
    // ----------------------------------------------------------------
    logic [22:0] hyst_q, hyst_d; // Active hysteresis
    logic [7:0] act_q, act_d; // Activation in force
    logic [7:0] comm_q, comm_d; // Commutation in force
    logic [7:0] act_pend_q, act_pend_d; // Pending activation
    logic [7:0] comm_pend_q, comm_pend_d; // Pending commutation

    // Pending capture each clock, apply only on the boundary
    always_comb
    begin
        hyst_d = hyst_q;
        act_pend_d = motor_activation_in;
        comm_pend_d = commutation_enable_in;
        act_d = act_q;
        comm_d = comm_q;
        if (backlash_hysteresis_we_in)
        begin
            hyst_d = backlash_hysteresis_in;
        end
        if (servo_tick_in)
        begin
            act_d = act_pend_q;
            comm_d = comm_pend_q;
        end
    end

    // Register settings
    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            hyst_q <= HYST_RESET;
            act_q <= ACTIVATION_RESET;
            comm_q <= '0;
            act_pend_q <= ACTIVATION_RESET;
            comm_pend_q <= '0;
        end
        else
        begin
            hyst_q <= hyst_d;
            act_q <= act_d;
            comm_q <= comm_d;
            act_pend_q <= act_pend_d;
            comm_pend_q <= comm_pend_d;
        end
    end

    // ----------------------------------------------------------------
    // Backlash hysteresis tracking, one slot per motor
    // ----------------------------------------------------------------
    logic [31:0] extreme_q [NUM_MOTORS]; // Last extreme position
    logic [NUM_MOTORS-1:0] dir_q; // 1 = negative direction
    logic [NUM_MOTORS-1:0] blash_q; // Backlash applied in new direction
    logic serve_ok; // Selected motor is active

    assign serve_ok = motor_go_in && act_q[motor_sel_in];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOTORS; gi++)
        begin : g_track
            logic [31:0] ext_d; // Next extreme
            logic dir_d; // Next direction
            logic bl_d; // Next backlash state
            logic [31:0] rev; // Reversal distance
            always_comb
            begin
                ext_d = extreme_q[gi];
                dir_d = dir_q[gi];
                bl_d = blash_q[gi];
                rev = dir_q[gi] ? (commanded_pos_in - extreme_q[gi])
                                : (extreme_q[gi] - commanded_pos_in);
                // Inactive motors keep stale tracking; no position work done
                if (serve_ok && motor_sel_in == 3'(gi))
                begin
                    if (!rev[31] && rev > {9'h0_00, hyst_q})
                    begin
                        // Reversal beyond hysteresis: flip and apply backlash
                        dir_d = ~dir_q[gi];
                        bl_d = 1'b1;
                        ext_d = commanded_pos_in;
                    end
                    else if (rev[31])
                    begin
                        // Moving further the same way: new extreme
                        ext_d = commanded_pos_in;
                    end
                end
            end
            always_ff @(posedge ref_clk_in)
            begin
                if (!nrst_in)
                begin
                    extreme_q[gi] <= '0;
                    dir_q[gi] <= 1'b0;
                    blash_q[gi] <= 1'b0;
                end
                else
                begin
                    extreme_q[gi] <= ext_d;
                    dir_q[gi] <= dir_d;
                    blash_q[gi] <= bl_d;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Route decode for the served motor
    // ----------------------------------------------------------------
    route_mode_e route; // Routing chosen this cycle
    logic is_pfm; // Channel set for pulse frequency
    logic alt_bit; // Bit 16 of output address

    assign is_pfm = (channel_output_mode_in == MODE_PFM_A)
                 || (channel_output_mode_in == MODE_PFM_B);
    assign alt_bit = command_output_address_in[ADDR_ALT_BIT];

    // Pick routing from commutation, loop, variant and address bits
    always_comb
    begin
        if (!comm_q[motor_sel_in])
        begin
            if (second_gen_in && is_pfm)
            begin
                route = ROUTE_PULSE;
            end
            else if (alt_bit && !second_gen_in)
            begin
                route = ROUTE_SIGN_MAG;
            end
            else
            begin
                route = ROUTE_SINGLE;
            end
        end
        else if (current_loop_select_in == 8'h00)
        begin
            route = alt_bit ? ROUTE_MICROSTEP : ROUTE_TWO_PHASE;
        end
        else
        begin
            route = ROUTE_THREE_PHASE;
        end
    end

    // ----------------------------------------------------------------
    // Write sequencer: one register write per clock
    // ----------------------------------------------------------------
    seq_state_e st_q, st_d; // Sequencer state
    logic [1:0] idx_q, idx_d; // Value index
    logic [1:0] last_q, last_d; // Last value index
    logic [15:0] base_q, base_d; // Lowest target address
    logic sx_q, sx_d; // X space select
    logic [23:0] v_q [3], v_d [3]; // Latched values
    logic sm_q, sm_d; // Sign-magnitude flag write pending
    logic [15:0] faddr_q, faddr_d; // Flag register address
    logic we_q, we_d; // Output write strobe
    logic [15:0] oa_q, oa_d; // Output address
    logic [23:0] od_q, od_d; // Output data
    logic fwe_q, fwe_d; // Flag write strobe
    logic fdir_q, fdir_d; // Flag direction
    logic [2:0] rm_q, rm_d; // Reported route

    // Next-state for the sequencer
    always_comb
    begin
        st_d = st_q;
        idx_d = idx_q;
        last_d = last_q;
        base_d = base_q;
        sx_d = sx_q;
        v_d = v_q;
        sm_d = sm_q;
        faddr_d = faddr_q;
        rm_d = rm_q;
        we_d = 1'b0;
        oa_d = oa_q; // Data held when idle, so outputs stay frozen
        od_d = od_q;
        fwe_d = 1'b0;
        fdir_d = fdir_q;
        case (st_q)
            SEQ_IDLE:
            begin
                if (serve_ok)
                begin
                    base_d = command_output_address_in[15:0];
                    sx_d = command_output_address_in[ADDR_SPACE_BIT];
                    faddr_d = flag_register_address_in[15:0];
                    rm_d = route;
                    v_d[0] = cmd_a_in;
                    v_d[1] = cmd_b_in;
                    v_d[2] = cmd_c_in;
                    sm_d = 1'b0;
                    idx_d = 2'd0;
                    case (route)
                        ROUTE_TWO_PHASE, ROUTE_MICROSTEP: last_d = 2'd1;
                        ROUTE_THREE_PHASE: last_d = 2'd2;
                        ROUTE_SIGN_MAG:
                        begin
                            // Magnitude only; sign goes to the flag register
                            last_d = 2'd0;
                            sm_d = 1'b1;
                            fdir_d = cmd_a_in[CMD_SIGN_BIT];
                            v_d[0] = cmd_a_in[CMD_SIGN_BIT] ? (24'h00_0000 - cmd_a_in)
                                                            : cmd_a_in;
                        end
                        default: last_d = 2'd0;
                    endcase
                    st_d = SEQ_WRITE;
                end
            end
            SEQ_WRITE:
            begin
                we_d = 1'b1;
                oa_d = base_q + {14'h0000, idx_q};
                od_d = v_q[idx_q];
                if (idx_q == last_q)
                begin
                    st_d = sm_q ? SEQ_FLAG : SEQ_IDLE;
                end
                else
                begin
                    idx_d = idx_q + 2'd1;
                end
            end
            SEQ_FLAG:
            begin
                fwe_d = 1'b1;
                st_d = SEQ_IDLE;
            end
            default: st_d = SEQ_IDLE;
        endcase
    end

    // Register sequencer state
    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            st_q <= SEQ_IDLE;
            idx_q <= '0;
            last_q <= '0;
            base_q <= '0;
            sx_q <= 1'b0;
            v_q <= '{default: '0};
            sm_q <= 1'b0;
            faddr_q <= '0;
            rm_q <= '0;
            we_q <= 1'b0;
            oa_q <= '0;
            od_q <= '0;
            fwe_q <= 1'b0;
            fdir_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            idx_q <= idx_d;
            last_q <= last_d;
            base_q <= base_d;
            sx_q <= sx_d;
            v_q <= v_d;
            sm_q <= sm_d;
            faddr_q <= faddr_d;
            rm_q <= rm_d;
            we_q <= we_d;
            oa_q <= oa_d;
            od_q <= od_d;
            fwe_q <= fwe_d;
            fdir_q <= fdir_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign backlash_hysteresis_out = hyst_q;
    assign active_motors_out = act_q;
    assign backlash_active_out = blash_q;
    assign direction_out = dir_q;
    assign route_mode_out = rm_q;
    assign out_we_out = we_q;
    assign out_space_x_out = sx_q;
    assign out_addr_out = oa_q;
    assign out_data_out = od_q;
    assign flag_we_out = fwe_q;
    assign flag_addr_out = faddr_q;
    assign flag_dir_out = fdir_q;
    assign busy_out = (st_q != SEQ_IDLE);

endmodule // motor_command_output_router

// *** motor_router_pkg.sv ***
// Package for the per-motor command output router.
// Assumes a single 20 MHz clock domain and eight motors.
package motor_router_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_MOTORS = 8;
    localparam int MOTOR_IDX_W = 3;
    localparam int ADDR_W = 20; // Extended address width
    localparam int REG_ADDR_W = 16; // Register address field width
    localparam int POS_W = 32; // Commanded position in 1/16 count
    localparam int CMD_W = 24; // Command value width
    localparam int HYST_W = 23; // Hysteresis setting width
    localparam int MODE_W = 2; // Channel output mode width
    localparam int LOOP_W = 8; // Current-loop setting width

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ADDR_SPACE_BIT = 19; // 1 = X space, 0 = Y space
    localparam int ADDR_ALT_BIT = 16; // Sign/magnitude or microstep select
    localparam int FLAG_DIR_BIT = 14; // Direction bit in flag register
    localparam int FLAG_NOENA_BIT = 16; // Flag address: no amp-enable use
    localparam int CMD_SIGN_BIT = 23; // Sign bit of command value

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [22:0] HYST_RESET = 23'h00_0040; // 64 sixteenths
    localparam logic [7:0] ACTIVATION_RESET = 8'h01; // Only motor 1 on
    localparam logic [19:0] DAC_GEN1_BASE = 20'h0_C002; // Pair base
    localparam logic [19:0] DAC_GEN2_BASE = 20'h0_C002; // A-side base
    localparam logic [19:0] DAC_PAIR_STEP = 20'h0_0008; // Pair spacing
    localparam logic [19:0] RING_BASE = 20'h0_C0A0; // Node 0 register 0
    localparam logic [19:0] RING_STEP = 20'h0_0004; // Per-node step
    localparam logic [19:0] PFM_C_OFFSET = 20'h0_0002; // C register offset

    // ----------------------------------------------------------------
    // Channel output modes producing pulse-frequency output
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_PFM_A = 2'h2;
    localparam logic [1:0] MODE_PFM_B = 2'h3;

    // Output routing modes
    typedef enum logic [2:0] {
        ROUTE_SINGLE,
        ROUTE_SIGN_MAG,
        ROUTE_TWO_PHASE,
        ROUTE_MICROSTEP,
        ROUTE_THREE_PHASE,
        ROUTE_PULSE
    } route_mode_e;

    // Write sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WRITE,
        SEQ_FLAG
    } seq_state_e;

endpackage

// *** motor_router_asserts.sv ***
// Concurrent checks on the command output router, bound to every instance.
// Assumes one clock domain and the router's synchronous active-low reset.
`timescale 1ns/100ps

module motor_router_asserts
    import motor_router_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic servo_tick_in,
    input wire logic [22:0] backlash_hysteresis_in,
    input wire logic backlash_hysteresis_we_in,
    input wire logic [7:0] motor_activation_in,
    input wire logic [19:0] command_output_address_in,
    input wire logic [2:0] motor_sel_in,
    input wire logic motor_go_in,
    input wire logic [22:0] backlash_hysteresis_out,
    input wire logic [7:0] active_motors_out,
    input wire logic [2:0] route_mode_out,
    input wire logic out_we_out,
    input wire logic out_space_x_out,
    input wire logic [15:0] out_addr_out,
    input wire logic [23:0] out_data_out,
    input wire logic flag_we_out,
    input wire logic busy_out
);
    // ------------------------------------------------------------
    // Common clocking and helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // Space bit and register address as the router should emit them
    wire logic [16:0] want_addr = {command_output_address_in[19], command_output_address_in[15:0]};

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_reset_values:
        assert property ($rose(nrst_in) |-> backlash_hysteresis_out == HYST_RESET
            && active_motors_out == ACTIVATION_RESET && !busy_out && !out_we_out)
        else $error("Reset values wrong");
    a_hyst_write:
        assert property (backlash_hysteresis_we_in
            |=> backlash_hysteresis_out == $past(backlash_hysteresis_in))
        else $error("Hysteresis write not taken");
    a_act_hold:
        assert property (!servo_tick_in |=> $stable(active_motors_out))
        else $error("Activation changed off a tick");
    a_act_apply:
        assert property ($past(nrst_in) && servo_tick_in && $stable(motor_activation_in)
            |=> active_motors_out == $past(motor_activation_in))
        else $error("Activation not applied at tick");
    a_serve_timing:
        assert property (motor_go_in && !busy_out && active_motors_out[motor_sel_in]
            |=> busy_out ##1 out_we_out && {out_space_x_out, out_addr_out} == $past(want_addr, 2))
        else $error("First write late or misaddressed");
    a_inactive_skip:
        assert property (motor_go_in && !busy_out && !active_motors_out[motor_sel_in]
            |=> !busy_out ##1 !out_we_out)
        else $error("Inactive motor served");
    a_two_values:
        assert property ($rose(out_we_out) && route_mode_out == ROUTE_TWO_PHASE
            |=> out_we_out && out_addr_out == 16'($past(out_addr_out) + 16'h0001) ##1 !out_we_out)
        else $error("Two-phase pair wrong");
    a_three_values:
        assert property ($rose(out_we_out) && route_mode_out == ROUTE_THREE_PHASE
            |=> (out_we_out && out_addr_out == 16'($past(out_addr_out) + 16'h0001)) [*2]
            ##1 !out_we_out)
        else $error("Three-phase triple wrong");
    a_single_value:
        assert property ($rose(out_we_out) && (route_mode_out == ROUTE_SINGLE
            || route_mode_out == ROUTE_PULSE || route_mode_out == ROUTE_SIGN_MAG) |=> !out_we_out)
        else $error("Extra write on single route");
    a_sign_split:
        assert property ($rose(out_we_out) && route_mode_out == ROUTE_SIGN_MAG
            |-> !out_data_out[CMD_SIGN_BIT] ##1 flag_we_out)
        else $error("Sign and magnitude not split");
endmodule // motor_router_asserts

bind motor_command_output_router motor_router_asserts i_chk (.*);

// *** output_reg_sink.sv ***
// Far-side model: output and flag registers that record every write.
// Assumes one write a clock, taken on the rising edge.
`timescale 1ns/100ps

module output_reg_sink
(
    input wire logic ref_clk_in,
    input wire logic out_we_in,
    input wire logic out_space_x_in,
    input wire logic [15:0] out_addr_in,
    input wire logic [23:0] out_data_in,
    input wire logic flag_we_in,
    input wire logic [15:0] flag_addr_in,
    input wire logic flag_dir_in
);
    logic [40:0] wr_log [$]; // Space, address, data
    logic [16:0] flag_log [$]; // Address, direction bit
    // Registers accept any write; the bench empties the logs
    always @(posedge ref_clk_in)
    begin
        if (out_we_in)
            wr_log.push_back({out_space_x_in, out_addr_in, out_data_in});
        if (flag_we_in)
            flag_log.push_back({flag_addr_in, flag_dir_in});
    end
endmodule // output_reg_sink

// *** tb.sv ***
// Self-checking bench for the command output router.
// Assumes the sink model logs every register write the router makes.
`timescale 1ns/100ps

module tb;
    import motor_router_pkg::*;
    logic ref_clk_in, nrst_in, servo_tick_in, second_gen_in, backlash_hysteresis_we_in;
    logic motor_go_in, out_we_out, out_space_x_out, flag_we_out, flag_dir_out, busy_out;
    logic [22:0] backlash_hysteresis_in, backlash_hysteresis_out;
    logic [7:0] motor_activation_in, commutation_enable_in, current_loop_select_in;
    logic [7:0] active_motors_out, backlash_active_out, direction_out;
    logic [19:0] command_output_address_in, flag_register_address_in;
    logic [1:0] channel_output_mode_in;
    logic [2:0] motor_sel_in, route_mode_out;
    logic [31:0] commanded_pos_in;
    logic [23:0] cmd_a_in, cmd_b_in, cmd_c_in, out_data_out, last;
    logic [15:0] out_addr_out, flag_addr_out;
    int miscompares, tests_run, hyst_m;
    int ext_m [8]; // Model: last extreme position
    bit dir_m [8], bl_m [8]; // Model: direction and backlash
    bit [7:0] act_m, comm_m; // Model: settings in force

    motor_command_output_router i_dut (.*);
    output_reg_sink i_sink (.ref_clk_in(ref_clk_in), .out_we_in(out_we_out),
        .out_space_x_in(out_space_x_out), .out_addr_in(out_addr_out), .out_data_in(out_data_out),
        .flag_we_in(flag_we_out), .flag_addr_in(flag_addr_out), .flag_dir_in(flag_dir_out));

    // ------------------------------------------------------------
    // Clock, compare and closing tasks
    // ------------------------------------------------------------
    initial
    begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input string nm, input logic [40:0] seen, input logic [40:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Settings only land at a tick, so the tick comes well after them
    task automatic cfg(input logic [7:0] act, input logic [7:0] comm);
        @(posedge ref_clk_in);
        motor_activation_in <= act;
        commutation_enable_in <= comm;
        repeat (2) @(posedge ref_clk_in);
        servo_tick_in <= 1'b1;
        @(posedge ref_clk_in);
        servo_tick_in <= 1'b0;
        act_m = act;
        comm_m = comm;
        @(posedge ref_clk_in);
        #1 check("active", active_motors_out, act);
    endtask

    // ------------------------------------------------------------
    // One serve of a motor against the model
    // ------------------------------------------------------------
    task automatic serve(input logic [2:0] m, input logic [19:0] adr, input logic [7:0] lp,
        input logic [1:0] md, input int pos);
        logic [23:0] v [3];
        logic [2:0] rt;
        int nw, k;
        v[0] = 24'($urandom);
        v[1] = 24'($urandom);
        v[2] = 24'($urandom);
        @(posedge ref_clk_in);
        if (!comm_m[m])
            rt = (second_gen_in && md[1]) ? ROUTE_PULSE
                : (!second_gen_in && adr[16]) ? ROUTE_SIGN_MAG : ROUTE_SINGLE;
        else if (lp == 8'h00)
            rt = adr[16] ? ROUTE_MICROSTEP : ROUTE_TWO_PHASE;
        else
            rt = ROUTE_THREE_PHASE;
        // Negative command, never the one without a magnitude
        if (rt == ROUTE_SIGN_MAG)
            v[0] = v[0] | 24'h80_0001;
        nw = (rt == ROUTE_THREE_PHASE) ? 3 : (rt inside {ROUTE_TWO_PHASE, ROUTE_MICROSTEP}) + 1;
        if (!act_m[m])
            nw = 0;
        motor_sel_in <= m;
        command_output_address_in <= adr;
        current_loop_select_in <= lp;
        channel_output_mode_in <= md;
        commanded_pos_in <= pos;
        cmd_a_in <= v[0];
        cmd_b_in <= v[1];
        cmd_c_in <= v[2];
        motor_go_in <= 1'b1;
        @(posedge ref_clk_in);
        motor_go_in <= 1'b0;
        k = 0;
        #1;
        while (busy_out === 1'b1 && k < 20)
        begin
            @(posedge ref_clk_in);
            #1 k++;
        end
        check("busy", busy_out, 1'b0);
        @(posedge ref_clk_in);
        #1 check("writes", i_sink.wr_log.size(), nw);
        for (k = 0; k < nw && k < i_sink.wr_log.size(); k++)
        begin
            check("addr", i_sink.wr_log[k][40:24], {adr[19], 16'(adr + k)});
            if (rt == ROUTE_SIGN_MAG)
                check("mag", i_sink.wr_log[k][23:0], 24'(-v[0]));
            else if (rt != ROUTE_MICROSTEP)
                check("data", i_sink.wr_log[k][23:0], v[k]);
            last = i_sink.wr_log[k][23:0];
        end
        check("flags", i_sink.flag_log.size(), act_m[m] && rt == ROUTE_SIGN_MAG);
        if (i_sink.flag_log.size() == 1)
            check("flag", i_sink.flag_log[0], {flag_register_address_in[15:0], 1'b1});
        i_sink.wr_log.delete();
        i_sink.flag_log.delete();
        if (!act_m[m])
            check("frozen", out_data_out, last);
        else
        begin
            check("route", route_mode_out, rt);
            if (dir_m[m] ? pos < ext_m[m] : pos > ext_m[m])
                ext_m[m] = pos;
            else if ((dir_m[m] ? pos - ext_m[m] : ext_m[m] - pos) > hyst_m)
            begin
                dir_m[m] = !dir_m[m];
                bl_m[m] = 1;
                ext_m[m] = pos;
            end
        end
        check("direction", direction_out[m], dir_m[m]);
        check("backlash", backlash_active_out[m], bl_m[m]);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        hyst_m = 64;
        act_m = 8'h01;
        void'($urandom(32'h5232));
        {nrst_in, servo_tick_in, second_gen_in, backlash_hysteresis_we_in, motor_go_in} = 5'h00;
        {backlash_hysteresis_in, current_loop_select_in, channel_output_mode_in} = '0;
        {motor_sel_in, commanded_pos_in, cmd_a_in, cmd_b_in, cmd_c_in} = '0;
        motor_activation_in = 8'h01;
        commutation_enable_in = 8'h00;
        command_output_address_in = 20'h0_0000;
        flag_register_address_in = 20'h1_C000; // Amp enable kept off the sign bit
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        #1 check("hysteresis", backlash_hysteresis_out, 23'h00_0040);
        check("active", active_motors_out, 8'h01);
        serve(3'h0, 20'h0_C003, 8'h00, 2'h0, 1000);
        serve(3'h0, 20'h0_C002, 8'h00, 2'h0, 936);
        serve(3'h0, 20'h8_C0A0, 8'h00, 2'h0, 935);
        serve(3'h0, 20'h1_C003, 8'h00, 2'h0, 999);
        serve(3'h1, 20'h0_C00B, 8'h00, 2'h0, 500);
        @(posedge ref_clk_in);
        backlash_hysteresis_in <= 23'h00_0010;
        backlash_hysteresis_we_in <= 1'b1;
        @(posedge ref_clk_in);
        backlash_hysteresis_we_in <= 1'b0;
        hyst_m = 16;
        #1 check("hysteresis", backlash_hysteresis_out, 23'h00_0010);
        serve(3'h0, 20'h0_C00B, 8'h00, 2'h0, 1017);
        second_gen_in <= 1'b1;
        serve(3'h0, 20'h0_C004, 8'h00, 2'h2, 1020);
        serve(3'h0, 20'h0_C00C, 8'h00, 2'h3, 1020);
        serve(3'h0, 20'h1_C002, 8'h00, 2'h0, 1020);
        cfg(8'h03, 8'h01);
        serve(3'h0, 20'h0_C00A, 8'h00, 2'h0, 1030);
        serve(3'h0, 20'h1_C00A, 8'h00, 2'h0, 1030);
        serve(3'h0, 20'h0_C0A4, 8'h05, 2'h0, 1030);
        serve(3'h1, 20'h0_C012, 8'h00, 2'h0, 40);
        cfg(8'h01, 8'h01);
        serve(3'h1, 20'h0_C012, 8'h00, 2'h0, -100);
        results();
    end
    initial
    begin
        #100000;
        miscompares++;
        results();
    end
endmodule // tb
